/* File: lane_test_pkg.sv */
// Register map, field layout and codes shared by the lane test logic
package lane_test_pkg;

    // ****************************************
    // Register indices (byte address = 4 x index)
    // ****************************************
    localparam logic [9:0] IDX_LANE_EN    = 10'h315;
    localparam logic [9:0] IDX_SEQ_CTRL   = 10'h316;
    localparam logic [9:0] IDX_LIMIT_0    = 10'h317;
    localparam logic [9:0] IDX_LIMIT_1    = 10'h318;
    localparam logic [9:0] IDX_LIMIT_2    = 10'h319;
    localparam logic [9:0] IDX_TALLY_0    = 10'h31a;
    localparam logic [9:0] IDX_TALLY_1    = 10'h31b;
    localparam logic [9:0] IDX_TALLY_2    = 10'h31c;
    localparam logic [9:0] IDX_PASS       = 10'h31d;
    localparam logic [9:0] IDX_SMP_CTRL   = 10'h32c;
    localparam logic [9:0] IDX_EXP_LOW    = 10'h32d;
    localparam logic [9:0] IDX_EXP_HIGH   = 10'h32e;
    localparam logic [9:0] IDX_SMP_RESULT = 10'h32f;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CLEAR_BIT    = 0;
    localparam int RUN_BIT      = 1;
    localparam int SEQ_SEL_LSB  = 2;
    localparam int LANE_SEL_LSB = 4;
    localparam int SMP_EN_BIT   = 0;
    localparam int SMP_CLR_BIT  = 1;
    localparam int SLOT_LSB     = 4;
    localparam int MISMATCH_BIT = 0;

    // ****************************************
    // Reset values and widths
    // ****************************************
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [23:0] RST_LIMIT = 24'h000000;
    localparam int          TALLY_W   = 24;
    localparam int          SAMPLE_W  = 16;

    // ****************************************
    // Codes and states
    // ****************************************
    typedef enum logic [1:0] {
        SEQ_P7  = 2'h0,
        SEQ_P15 = 2'h1,
        SEQ_P31 = 2'h2
    } seq_type;

    typedef enum logic {
        RUN_IDLE   = 1'b0,
        RUN_ACTIVE = 1'b1
    } run_state_type;

endpackage

/* File: seq_lane_checker.sv */
// Self-synchronising pseudo-random sequence checker for one lane
`timescale 1ns/1ns
module seq_lane_checker (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clear_i,
    input  wire logic        run_i,
    input  wire logic        enable_i,
    input  wire logic [1:0]  seq_sel_i,
    input  wire logic        bit_valid_i,
    input  wire logic        bit_i,
    input  wire logic [23:0] limit_i,
    output logic      [23:0] tally_o,
    output logic             pass_o
);

    logic [30:0] hist_r;
    logic [4:0]  fill_r;
    logic [4:0]  fill_len;
    logic        predicted;

    // ****************************************
    // Sequence taps
    // ****************************************
    always_comb begin
        case (seq_sel_i)
            lane_test_pkg::SEQ_P15: begin
                predicted = hist_r[14] ^ hist_r[13];
                fill_len  = 5'h0f;
            end
            lane_test_pkg::SEQ_P31: begin
                predicted = hist_r[30] ^ hist_r[27];
                fill_len  = 5'h1f;
            end
            default: begin
                predicted = hist_r[6] ^ hist_r[5];
                fill_len  = 5'h07;
            end
        endcase
    end

    // History runs on every bit, independent of link state
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            hist_r <= 31'h00000000;
        end else if (bit_valid_i) begin
            hist_r <= {hist_r[29:0], bit_i};
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fill_r <= 5'h00;
        end else if (clear_i || !enable_i) begin
            fill_r <= 5'h00;
        end else if (bit_valid_i && fill_r != fill_len) begin
            fill_r <= fill_r + 5'h01;
        end
    end

    // ****************************************
    // Error tally and pass flag
    // ****************************************
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tally_o <= 24'h000000;
        end else if (clear_i) begin
            tally_o <= 24'h000000;
        end else if (run_i && enable_i && bit_valid_i && fill_r == fill_len
                     && bit_i != predicted && tally_o != 24'hffffff) begin
            tally_o <= tally_o + 24'h000001;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pass_o <= 1'b1;
        end else if (run_i && enable_i && tally_o >= limit_i) begin
            pass_o <= 1'b0;
        end else if (clear_i) begin
            pass_o <= 1'b1;
        end
    end

    tally_sat_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        tally_o == 24'hffffff && !clear_i |=> tally_o == 24'hffffff)
        else $error("error tally left saturation");

    pass_drop_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        run_i && enable_i && tally_o >= limit_i |=> !pass_o)
        else $error("pass flag kept over limit");

    clear_all_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        clear_i && !run_i |=> tally_o == 24'h000000 && pass_o)
        else $error("clear did not reset checker");

endmodule

/* File: serial_rx_lane_test_checker.sv */
// Lane sequence checkers and transport sample check behind an Avalon-MM slave
`timescale 1ns/1ns
module serial_rx_lane_test_checker #(
    parameter int LANES = 8
) (
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    input  wire logic [11:0]          address_i,
    input  wire logic                 read_i,
    input  wire logic                 write_i,
    input  wire logic [31:0]          writedata_i,
    input  wire logic [3:0]           byteenable_i,
    output logic      [31:0]          readdata_o,
    output logic                      waitrequest_o,
    input  wire logic [LANES-1:0]     lane_bit_valid_i,
    input  wire logic [LANES-1:0]     lane_bit_i,
    input  wire logic [3:0]           link_lanes_i,
    input  wire logic                 single_conv_i,
    input  wire logic                 smp_valid_i,
    input  wire logic                 smp_conv_i,
    input  wire logic [1:0]           smp_index_i,
    input  wire logic [15:0]          smp_data_i
);

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0]       lane_check_enable_r;
    logic [7:0]       seq_test_control_r;
    logic [23:0]      seq_error_limit_r;
    logic [7:0]       sample_check_control_r;
    logic [7:0]       expected_sample_low_r;
    logic [7:0]       expected_sample_high_r;
    logic             sample_mismatch_flag_r;
    logic             ack_r;
    logic             run_bit_d_r;
    logic [31:0]      rd_nxt;
    lane_test_pkg::run_state_type run_state_r;

    logic [9:0]       reg_index;
    logic             wr_take;
    logic             lane_wr;
    logic [7:0]       wr_byte;

    logic             checker_clear;
    logic             run_trigger;
    logic [1:0]       sequence_select;
    logic [2:0]       count_lane_select;
    logic             sample_check_enable;
    logic             sample_check_clear;
    logic [3:0]       sample_slot_select;

    logic [23:0]      tally_w [LANES];
    logic [LANES-1:0] lane_pass_flags;
    logic [23:0]      lane_error_tally;

    logic             target_conv;
    logic [1:0]       target_index;
    logic             bad_mode;
    logic             slot_hit;
    logic [15:0]      expected_sample;

    // ****************************************
    // Bus slave: one wait cycle per access
    // ****************************************
    assign reg_index     = address_i[11:2];
    assign waitrequest_o = (read_i || write_i) && !ack_r;
    assign wr_take       = write_i && ack_r;
    assign lane_wr       = wr_take && byteenable_i[0];
    assign wr_byte       = writedata_i[7:0];

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (read_i || write_i) && !ack_r;
        end
    end

    // ****************************************
    // Field views
    // ****************************************
    assign checker_clear       = seq_test_control_r[lane_test_pkg::CLEAR_BIT];
    assign run_trigger         = seq_test_control_r[lane_test_pkg::RUN_BIT];
    assign sequence_select     = seq_test_control_r[lane_test_pkg::SEQ_SEL_LSB +: 2];
    assign count_lane_select   = seq_test_control_r[lane_test_pkg::LANE_SEL_LSB +: 3];
    assign sample_check_enable = sample_check_control_r[lane_test_pkg::SMP_EN_BIT];
    assign sample_check_clear  = sample_check_control_r[lane_test_pkg::SMP_CLR_BIT];
    assign sample_slot_select  = sample_check_control_r[lane_test_pkg::SLOT_LSB +: 4];
    assign expected_sample     = {expected_sample_high_r, expected_sample_low_r};

    // ****************************************
    // Writable registers
    // ****************************************
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lane_check_enable_r <= lane_test_pkg::RST_BYTE;
        end else if (lane_wr && reg_index == lane_test_pkg::IDX_LANE_EN) begin
            lane_check_enable_r <= wr_byte;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_test_control_r <= lane_test_pkg::RST_BYTE;
        end else if (lane_wr && reg_index == lane_test_pkg::IDX_SEQ_CTRL) begin
            seq_test_control_r <= wr_byte;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            seq_error_limit_r <= lane_test_pkg::RST_LIMIT;
        end else if (lane_wr) begin
            if (reg_index == lane_test_pkg::IDX_LIMIT_0) begin
                seq_error_limit_r[7:0] <= wr_byte;
            end else if (reg_index == lane_test_pkg::IDX_LIMIT_1) begin
                seq_error_limit_r[15:8] <= wr_byte;
            end else if (reg_index == lane_test_pkg::IDX_LIMIT_2) begin
                seq_error_limit_r[23:16] <= wr_byte;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_check_control_r <= lane_test_pkg::RST_BYTE;
        end else if (lane_wr && reg_index == lane_test_pkg::IDX_SMP_CTRL) begin
            sample_check_control_r <= wr_byte;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            expected_sample_low_r  <= lane_test_pkg::RST_BYTE;
            expected_sample_high_r <= lane_test_pkg::RST_BYTE;
        end else if (lane_wr) begin
            if (reg_index == lane_test_pkg::IDX_EXP_LOW) begin
                expected_sample_low_r <= wr_byte;
            end else if (reg_index == lane_test_pkg::IDX_EXP_HIGH) begin
                expected_sample_high_r <= wr_byte;
            end
        end
    end

    // ****************************************
    // Run control: starts on rising edge of the run bit
    // ****************************************
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_bit_d_r <= 1'b0;
        end else begin
            run_bit_d_r <= run_trigger;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_state_r <= lane_test_pkg::RUN_IDLE;
        end else begin
            case (run_state_r)
                lane_test_pkg::RUN_IDLE: begin
                    if (run_trigger && !run_bit_d_r) begin
                        run_state_r <= lane_test_pkg::RUN_ACTIVE;
                    end
                end
                default: begin
                    if (!run_trigger) begin
                        run_state_r <= lane_test_pkg::RUN_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Per-lane checkers
    // ****************************************
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        seq_lane_checker u_chk (
            .ref_clk_i   (ref_clk_i),
            .rst_i       (rst_i),
            .clear_i     (checker_clear),
            .run_i       (run_state_r == lane_test_pkg::RUN_ACTIVE),
            .enable_i    (lane_check_enable_r[g]),
            .seq_sel_i   (sequence_select),
            .bit_valid_i (lane_bit_valid_i[g]),
            .bit_i       (lane_bit_i[g]),
            .limit_i     (seq_error_limit_r),
            .tally_o     (tally_w[g]),
            .pass_o      (lane_pass_flags[g])
        );
    end

    assign lane_error_tally = tally_w[count_lane_select];

    // ****************************************
    // Transport sample check
    // ****************************************
    always_comb begin
        if (single_conv_i) begin
            target_conv  = 1'b0;
            target_index = {sample_slot_select[0], sample_slot_select[1]};
        end else begin
            target_conv  = sample_slot_select[0];
            target_index = (link_lanes_i == 4'h8) ? {1'b0, sample_slot_select[1]} : 2'h0;
        end
    end

    assign bad_mode = (link_lanes_i == 4'h3) || (link_lanes_i == 4'h6);
    assign slot_hit = smp_valid_i && smp_conv_i == target_conv && smp_index_i == target_index;

    // Set wins over the clear pulse so no event is lost
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sample_mismatch_flag_r <= 1'b0;
        end else if (sample_check_enable && bad_mode) begin
            sample_mismatch_flag_r <= 1'b1;
        end else if (sample_check_enable && slot_hit && smp_data_i != expected_sample) begin
            sample_mismatch_flag_r <= 1'b1;
        end else if (sample_check_clear) begin
            sample_mismatch_flag_r <= 1'b0;
        end
    end

    // ****************************************
    // Read mux; unmapped addresses read zero
    // ****************************************
    always_comb begin
        rd_nxt = 32'h00000000;
        if (reg_index == lane_test_pkg::IDX_LANE_EN) begin
            rd_nxt[7:0] = lane_check_enable_r;
        end else if (reg_index == lane_test_pkg::IDX_SEQ_CTRL) begin
            rd_nxt[7:0] = seq_test_control_r;
        end else if (reg_index == lane_test_pkg::IDX_LIMIT_0) begin
            rd_nxt[7:0] = seq_error_limit_r[7:0];
        end else if (reg_index == lane_test_pkg::IDX_LIMIT_1) begin
            rd_nxt[7:0] = seq_error_limit_r[15:8];
        end else if (reg_index == lane_test_pkg::IDX_LIMIT_2) begin
            rd_nxt[7:0] = seq_error_limit_r[23:16];
        end else if (reg_index == lane_test_pkg::IDX_TALLY_0) begin
            rd_nxt[7:0] = lane_error_tally[7:0];
        end else if (reg_index == lane_test_pkg::IDX_TALLY_1) begin
            rd_nxt[7:0] = lane_error_tally[15:8];
        end else if (reg_index == lane_test_pkg::IDX_TALLY_2) begin
            rd_nxt[7:0] = lane_error_tally[23:16];
        end else if (reg_index == lane_test_pkg::IDX_PASS) begin
            rd_nxt[LANES-1:0] = lane_pass_flags;
        end else if (reg_index == lane_test_pkg::IDX_SMP_CTRL) begin
            rd_nxt[7:0] = sample_check_control_r;
        end else if (reg_index == lane_test_pkg::IDX_EXP_LOW) begin
            rd_nxt[7:0] = expected_sample_low_r;
        end else if (reg_index == lane_test_pkg::IDX_EXP_HIGH) begin
            rd_nxt[7:0] = expected_sample_high_r;
        end else if (reg_index == lane_test_pkg::IDX_SMP_RESULT) begin
            rd_nxt[lane_test_pkg::MISMATCH_BIT] = sample_mismatch_flag_r;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            readdata_o <= 32'h00000000;
        end else if (read_i && !ack_r) begin
            readdata_o <= rd_nxt;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence rd_req_s(logic [9:0] idx);
        read_i && !ack_r && reg_index == idx;
    endsequence

    sequence ctrl_wr_s;
        lane_wr && reg_index == lane_test_pkg::IDX_SEQ_CTRL;
    endsequence

    bus_answer_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (read_i || write_i) && !ack_r |=> !waitrequest_o || !(read_i || write_i))
        else $error("access not answered after one wait cycle");

    seq_select_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ctrl_wr_s |=> sequence_select == $past(writedata_i[3:2]))
        else $error("sequence select not stored");

    lane_enable_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        lane_wr && reg_index == lane_test_pkg::IDX_LANE_EN |=> lane_check_enable_r == $past(wr_byte))
        else $error("lane enable not stored");

    limit_low_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        lane_wr && reg_index == lane_test_pkg::IDX_LIMIT_0 |=> seq_error_limit_r[7:0] == $past(wr_byte))
        else $error("limit low byte not stored");

    run_start_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(run_state_r == lane_test_pkg::RUN_ACTIVE) |-> $past(run_trigger) && !$past(run_bit_d_r))
        else $error("run began without rising edge");

    pass_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_req_s(lane_test_pkg::IDX_PASS) |=> readdata_o[LANES-1:0] == $past(lane_pass_flags))
        else $error("pass flags misread");

    tally_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        rd_req_s(lane_test_pkg::IDX_TALLY_2) |=> readdata_o[7:0] == $past(lane_error_tally[23:16]))
        else $error("selected tally misread");

    mismatch_set_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sample_check_enable && slot_hit && smp_data_i != expected_sample |=> sample_mismatch_flag_r)
        else $error("mismatch not flagged");

    check_gate_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !sample_check_enable && !sample_mismatch_flag_r |=> !sample_mismatch_flag_r)
        else $error("flag set while check disabled");

    bad_mode_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sample_check_enable && bad_mode |=> sample_mismatch_flag_r)
        else $error("three or six lane check passed");

    mismatch_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sample_mismatch_flag_r && !sample_check_clear |=> sample_mismatch_flag_r)
        else $error("mismatch flag dropped early");

    sample_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sample_check_clear && !sample_check_enable |=> !sample_mismatch_flag_r)
        else $error("sample clear ignored");

    slot_map_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        single_conv_i && sample_slot_select[1:0] == 2'h1 |-> target_index == 2'h2 && !target_conv)
        else $error("single converter slot map wrong");

endmodule

/* File: tx_model.sv */
// Far-side transmitter model: sequence bits on every lane and repeating frame samples
`timescale 1ns/1ns
module tx_model (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  flip_i,
    input  wire logic        single_conv_i,
    output logic      [7:0]  bit_valid_o,
    output logic      [7:0]  bit_o,
    output logic             smp_valid_o,
    output logic             smp_conv_o,
    output logic      [1:0]  smp_index_o,
    output logic      [15:0] smp_data_o
);
    logic [6:0] lfsr_r;
    logic [1:0] slot_r;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lfsr_r <= 7'h7f;
            slot_r <= 2'h0;
        end else begin
            lfsr_r <= {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
            slot_r <= slot_r + 2'h1;
        end
    end
    // Flip injects single bit errors on chosen lanes
    assign bit_valid_o = {8{~rst_i}};
    assign bit_o       = {8{lfsr_r[6] ^ lfsr_r[5]}} ^ flip_i;
    assign smp_valid_o = ~rst_i;
    assign smp_conv_o  = single_conv_i ? 1'b0 : slot_r[0];
    assign smp_index_o = single_conv_i ? slot_r : {1'b0, slot_r[1]};
    assign smp_data_o  = 16'h5a00 + {13'h0, smp_conv_o, smp_index_o};
endmodule

/* File: tb_top.sv */
// Self-checking bench: register access, lane sequence checks and sample checks
`timescale 1ns/1ns
`define CHK(nm, ev, got) begin num_checks++; if ((got) !== (ev)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, ev, got); end end
module tb_top;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [11:0] address_i = 12'h000;
    logic        read_i = 1'b0;
    logic        write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    logic [7:0]  bit_valid, lane_bits, q;
    logic [7:0]  flip = 8'h00;
    logic [3:0]  link_lanes_i = 4'h8;
    logic        single_conv_i = 1'b0;
    logic        smp_valid, smp_conv;
    logic [1:0]  smp_index;
    logic [15:0] smp_data;
    int          n_fail = 0;
    int          num_checks = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    serial_rx_lane_test_checker #(.LANES(8)) dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hf),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .lane_bit_valid_i(bit_valid),
        .lane_bit_i(lane_bits), .link_lanes_i(link_lanes_i), .single_conv_i(single_conv_i),
        .smp_valid_i(smp_valid), .smp_conv_i(smp_conv), .smp_index_i(smp_index), .smp_data_i(smp_data));
    tx_model tx_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .flip_i(flip), .single_conv_i(single_conv_i),
        .bit_valid_o(bit_valid), .bit_o(lane_bits), .smp_valid_o(smp_valid), .smp_conv_o(smp_conv),
        .smp_index_o(smp_index), .smp_data_o(smp_data));
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One bus cycle, entered just after a rising edge; waits for waitrequest low
    task automatic acc(input logic [9:0] idx, input logic we, input logic [7:0] d);
        int k;
        address_i   <= {idx, 2'b00};
        read_i      <= ~we;
        write_i     <= we;
        writedata_i <= {24'h0, d};
        k = 0;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (waitrequest_o !== 1'b0 && k < 20);
        q = readdata_o[7:0];
        read_i  <= 1'b0;
        write_i <= 1'b0;
        if (waitrequest_o !== 1'b0) begin
            n_fail++;
            tally_and_finish;
        end
        @(posedge ref_clk_i);
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [7:0] ev, input string nm);
        acc(idx, 1'b0, 8'h00);
        `CHK(nm, ev, q)
    endtask
    task automatic smp(input logic [3:0] slot, input logic [15:0] ev, input logic m1, input logic [3:0] ll,
                       input logic fl);
        single_conv_i <= m1;
        link_lanes_i  <= ll;
        acc(lane_test_pkg::IDX_EXP_LOW, 1'b1, ev[7:0]);
        acc(lane_test_pkg::IDX_EXP_HIGH, 1'b1, ev[15:8]);
        acc(lane_test_pkg::IDX_SMP_CTRL, 1'b1, {slot, 4'h1});
        acc(lane_test_pkg::IDX_SMP_CTRL, 1'b1, {slot, 4'h3});
        acc(lane_test_pkg::IDX_SMP_CTRL, 1'b1, {slot, 4'h1});
        repeat (8) @(posedge ref_clk_i);
        rdc(lane_test_pkg::IDX_SMP_RESULT, {7'h0, fl}, "mismatch");
    endtask
    // Cleared run with a chosen sequence code against the 7-bit stream from the far side
    task automatic seq_run(input logic [1:0] code, input logic [7:0] ev);
        acc(lane_test_pkg::IDX_SEQ_CTRL, 1'b1, {4'h0, code, 2'h1});
        acc(lane_test_pkg::IDX_SEQ_CTRL, 1'b1, {4'h0, code, 2'h0});
        acc(lane_test_pkg::IDX_SEQ_CTRL, 1'b1, {4'h0, code, 2'h2});
        repeat (100) @(posedge ref_clk_i);
        acc(lane_test_pkg::IDX_SEQ_CTRL, 1'b1, {4'h0, code, 2'h0});
        rdc(lane_test_pkg::IDX_PASS, ev, "pass_seq");
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rdc(lane_test_pkg::IDX_PASS, 8'hff, "pass_rst");
        rdc(lane_test_pkg::IDX_SEQ_CTRL, 8'h00, "ctrl_rst");
        rdc(10'h300, 8'h00, "unmapped");
        acc(lane_test_pkg::IDX_LIMIT_0, 1'b1, 8'h05);
        acc(lane_test_pkg::IDX_LIMIT_1, 1'b1, 8'h00);
        acc(lane_test_pkg::IDX_LIMIT_2, 1'b1, 8'h00);
        rdc(lane_test_pkg::IDX_LIMIT_0, 8'h05, "limit_lo");
        acc(lane_test_pkg::IDX_LANE_EN, 1'b1, 8'h03);
        acc(lane_test_pkg::IDX_SEQ_CTRL, 1'b1, 8'h01);
        acc(lane_test_pkg::IDX_SEQ_CTRL, 1'b1, 8'h00);
        acc(lane_test_pkg::IDX_SEQ_CTRL, 1'b1, 8'h02);
        repeat (40) @(posedge ref_clk_i);
        repeat (2) begin
            flip <= 8'h02;
            @(posedge ref_clk_i);
            flip <= 8'h00;
            repeat (20) @(posedge ref_clk_i);
        end
        acc(lane_test_pkg::IDX_SEQ_CTRL, 1'b1, 8'h00);
        rdc(lane_test_pkg::IDX_PASS, 8'hfd, "pass_run");
        acc(lane_test_pkg::IDX_SEQ_CTRL, 1'b1, 8'h10);
        rdc(lane_test_pkg::IDX_TALLY_0, 8'h06, "tally1_lo");
        rdc(lane_test_pkg::IDX_TALLY_1, 8'h00, "tally1_mid");
        acc(lane_test_pkg::IDX_SEQ_CTRL, 1'b1, 8'h00);
        rdc(lane_test_pkg::IDX_TALLY_0, 8'h00, "tally0_lo");
        acc(lane_test_pkg::IDX_SEQ_CTRL, 1'b1, 8'h11);
        rdc(lane_test_pkg::IDX_TALLY_0, 8'h00, "tally_clr");
        seq_run(2'h1, 8'hfc);
        seq_run(2'h2, 8'hfc);
        seq_run(2'h3, 8'hff);
        smp(4'h1, 16'h5a04, 1'b0, 4'h8, 1'b0);
        smp(4'h6, 16'h5a01, 1'b0, 4'h8, 1'b0);
        smp(4'h3, 16'h5a00, 1'b0, 4'h8, 1'b1);
        acc(lane_test_pkg::IDX_EXP_LOW, 1'b1, 8'h05);
        rdc(lane_test_pkg::IDX_SMP_RESULT, 8'h01, "sticky");
        smp(4'hd, 16'h5a02, 1'b1, 4'h8, 1'b0);
        smp(4'h2, 16'h5a01, 1'b1, 4'h8, 1'b0);
        smp(4'h0, 16'h5a00, 1'b0, 4'h3, 1'b1);
        smp(4'h0, 16'h5a00, 1'b0, 4'h6, 1'b1);
        acc(lane_test_pkg::IDX_SMP_CTRL, 1'b1, 8'h02);
        acc(lane_test_pkg::IDX_SMP_CTRL, 1'b1, 8'h00);
        repeat (8) @(posedge ref_clk_i);
        rdc(lane_test_pkg::IDX_SMP_RESULT, 8'h00, "disabled");
        tally_and_finish;
    end
endmodule
